// ---- hw/fbk_flash_ctrl.sv ----
// Notes on behaviour
// - Unmapped reads give zero, unmapped writes ignored
// - Program flash spans 0x2_0000 to 0x3_FFFF
// - Lower, higher and remaining regions protect separately
// - Field holds key, reserved, protection, option, security
// - Unsecure with nonzero index sets access error
// - Unsecure outside permitted mode sets access error
// - Unsecure with any protection sets violation flag
// - Verify errors set upper; uncorrectable sets lower
// - Backdoor disabled by key enable bits gives error
// - All keys matching stored words release security
// - Mismatch locks further backdoor attempts until reset
// - Clearing complete flag launches; controller sets it after
//
// Implementation choices: the plain strobed port and the address map.
module fbk_flash_ctrl #(
  parameter int unsigned KEY_WORDS = 4,        // Keys per verification
  parameter logic [127:0] FIELD_INIT = {
    64'h1234_5678_9ABC_DEF0, 32'hFFFF_FFFF,
    8'h00, 8'h00, 8'hFF, 8'h80}                // Key values arbitrary
) (
  input  wire  logic        clk,
  input  wire  logic        reset,
  input  wire  logic [7:0]  addr,
  input  wire  logic [15:0] wdata,
  input  wire  logic        wr,
  input  wire  logic        rd,
  output logic       [15:0] rdata,
  input  wire  logic        special_mode,
  input  wire  logic        verify_fault,
  input  wire  logic        verify_uncorrectable,
  output logic              irq,
  output logic              secured
);
  import fbk_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]      rdata;     // Read data, one cycle
    logic             irq;       // Interrupt level
    logic             secured;   // Security in force
    logic             loaded;    // Security caught after reset
    logic             lockout;   // Backdoor locked until reset
    logic             command_complete_flag;      // command_complete_flag
    logic             access_error_flag;    // access_error_flag
    logic             protection_violation_flag;    // protection_violation_flag
    logic             mg1;       // verify_error_status_upper
    logic             mg0;       // verify_error_status_lower
    logic [2:0]       idx;       // command_index_pointer
    logic [4:0][15:0] param;     // command_parameter_words
    logic [3:0]       ist;       // Interrupt status
    logic [3:0]       imask;     // Interrupt mask
    logic [15:0]      qaddr;     // Query address bits 17:2
    logic [1:0]       kidx;      // Key under comparison
    logic             mismatch;  // Any key differed
    fbk_state_type    st;        // Sequence state
  } fbk_regs_type;

  localparam fbk_regs_type REGS_RESET = '{
    rdata: 16'h0000, irq: 1'b0, secured: 1'b1, loaded: 1'b0,
    lockout: 1'b0, command_complete_flag: 1'b1, access_error_flag: 1'b0, protection_violation_flag: 1'b0,
    mg1: 1'b0, mg0: 1'b0, idx: 3'h0, param: '0, ist: 4'h0,
    imask: 4'h0, qaddr: 16'h0000, kidx: 2'h0, mismatch: 1'b0,
    st: ST_IDLE};

  fbk_regs_type r_q;  // Registered state
  fbk_regs_type r_d;  // Next state
  fbk_cfg_if    cfg (); // Field lookup

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Region span from a two-bit size code
  function automatic logic [17:0] region_size(input logic [1:0] code);
    return 18'(REGION_UNIT << code);
  endfunction

  // Protection of one byte address under a protection byte
  function automatic logic addr_prot(input logic [17:0] a,
                                     input logic [7:0]  p);
    logic in_win;
    logic in_hi;
    logic in_lo;
    in_win = (a >= PF_BASE) && (a <= PF_TOP);
    in_hi  = in_win && (a > PF_TOP -
             region_size(p[PROT_HI_SZ +: 2]));
    in_lo  = (a >= LOWER_BASE) && (a < LOWER_BASE +
             region_size(p[PROT_LO_SZ +: 2]));
    if (!in_win) begin
      return 1'b0;
    end else if (in_hi) begin
      return p[PROT_HI_EN];
    end else if (in_lo) begin
      return p[PROT_LO_EN];
    end else begin
      return p[PROT_OT_EN];
    end
  endfunction

  // Write-one-to-clear flag where a set in the same cycle wins
  function automatic logic w1c(input logic cur, input logic set,
                               input logic clr);
    return set | (cur & ~clr);
  endfunction

  // ----------------------------------------------------------------
  // Field store
  // ----------------------------------------------------------------
  fbk_cfg_field #(
    .FIELD_INIT (FIELD_INIT)
  ) u_field (
    .cfg (cfg.store)
  );

  assign cfg.key_sel = r_q.kidx;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0]  ev;        // Events this cycle
    logic        set_acc;   // Access error raised
    logic        set_fpv;   // Violation raised
    logic        wr_stat;   // Write to status register
    logic        any_prot;  // Some flash area protected
    logic [17:0] qbyte;     // Query byte address
    logic [7:0]  cmd;       // Command code
    ev       = 4'h0;
    set_acc  = 1'b0;
    set_fpv  = 1'b0;
    wr_stat  = wr && (addr == REG_STATUS);
    any_prot = (cfg.pprot[PROT_OT_EN:PROT_HI_EN] != 3'h0) ||
               (cfg.dprot != 8'h00);
    qbyte    = {r_q.qaddr, 2'b00};
    cmd      = r_q.param[0][15:8];
    r_d      = r_q;
    r_d.rdata = 16'h0000;

    // Catch the stored security state once after reset
    if (!r_q.loaded) begin
      r_d.loaded  = 1'b1;
      r_d.secured = (cfg.sec[1:0] != SEC_OPEN);
    end

    // Command sequence
    case (r_q.st)
      ST_IDLE: begin
        // Writing one to the complete flag launches
        if (wr_stat && wdata[ST_COMMAND_COMPLETE_FLAG] && r_q.command_complete_flag) begin
          r_d.command_complete_flag   = 1'b0;
          r_d.access_error_flag = 1'b0;
          r_d.protection_violation_flag = 1'b0;
          r_d.mg1    = 1'b0;
          r_d.mg0    = 1'b0;
          r_d.st     = ST_LAUNCH;
        end
      end
      ST_LAUNCH: begin
        r_d.st   = ST_IDLE;
        r_d.command_complete_flag = 1'b1;
        if (cmd == CMD_BACKDOOR) begin
          if (r_q.idx != IDX_BACKDOOR) begin
            set_acc = 1'b1;
          end else if (cfg.sec[7:6] != BACKDOOR_KEY_ENABLE_BITS_ON) begin
            set_acc = 1'b1;
          end else if (r_q.lockout) begin
            set_acc = 1'b1;
          end else begin
            r_d.command_complete_flag     = 1'b0;
            r_d.kidx     = 2'h0;
            r_d.mismatch = 1'b0;
            r_d.st       = ST_COMPARE;
          end
        end else if (cmd == CMD_UNSECURE) begin
          if (r_q.idx != 3'h0) begin
            set_acc = 1'b1;
          end else if (!special_mode) begin
            set_acc = 1'b1;
          end else if (any_prot) begin
            set_fpv = 1'b1;
          end else begin
            r_d.mg1 = verify_fault | verify_uncorrectable;
            r_d.mg0 = verify_uncorrectable;
            if (!(verify_fault | verify_uncorrectable)) begin
              r_d.secured = 1'b0;
              ev[EV_UNLOCK] = 1'b1;
            end
          end
        end else begin
          set_acc = 1'b1;
        end
        ev[EV_DONE] = r_d.command_complete_flag;
      end
      ST_COMPARE: begin
        // One key word per cycle, Key 0 first
        if (r_q.param[r_q.kidx + 3'h1] != cfg.key_word) begin
          r_d.mismatch = 1'b1;
        end
        r_d.kidx = r_q.kidx + 2'h1;
        if (32'(r_q.kidx) == KEY_WORDS - 1) begin
          r_d.st        = ST_IDLE;
          r_d.command_complete_flag      = 1'b1;
          ev[EV_DONE]   = 1'b1;
          if (r_d.mismatch) begin
            r_d.lockout = 1'b1;
          end else begin
            r_d.secured   = 1'b0;
            ev[EV_UNLOCK] = 1'b1;
          end
        end
      end
      default: begin
        r_d.st = ST_IDLE;
      end
    endcase

    // Error flags: write one clears, a new error wins
    r_d.access_error_flag = w1c(r_d.access_error_flag, set_acc,
                     wr_stat && wdata[ST_ACCESS_ERROR_FLAG]);
    r_d.protection_violation_flag = w1c(r_d.protection_violation_flag, set_fpv,
                     wr_stat && wdata[ST_PROTECTION_VIOLATION_FLAG]);
    ev[EV_ACCESS_ERROR_FLAG] = set_acc;
    ev[EV_PROTECTION_VIOLATION_FLAG] = set_fpv;

    // Register writes; unmapped offsets do nothing
    if (wr) begin
      if (addr == REG_INT_MASK) begin
        r_d.imask = wdata[3:0];
      end else if (addr == REG_INDEX) begin
        r_d.idx = wdata[2:0];
      end else if (addr == REG_PARAM) begin
        if (r_q.command_complete_flag && r_q.idx <= IDX_BACKDOOR) begin
          r_d.param[r_q.idx] = wdata;
        end
      end else if (addr == REG_QADDR) begin
        r_d.qaddr = wdata;
      end
    end

    // Interrupt status: events set, write one clears
    for (int i = 0; i < 4; i++) begin
      r_d.ist[i] = w1c(r_q.ist[i], ev[i],
                       wr && (addr == REG_INT_STAT) && wdata[i]);
    end
    r_d.irq = (r_d.ist & r_d.imask) != 4'h0;

    // Register reads, data one cycle later
    if (rd) begin
      if (addr == REG_STATUS) begin
        r_d.rdata = {8'h00, r_q.command_complete_flag, 1'b0, r_q.access_error_flag, r_q.protection_violation_flag,
                     2'b00, r_q.mg1, r_q.mg0};
      end else if (addr == REG_INT_STAT) begin
        r_d.rdata = {12'h000, r_q.ist};
      end else if (addr == REG_INT_MASK) begin
        r_d.rdata = {12'h000, r_q.imask};
      end else if (addr == REG_INDEX) begin
        r_d.rdata = {13'h0000, r_q.idx};
      end else if (addr == REG_PARAM) begin
        r_d.rdata = (r_q.idx <= IDX_BACKDOOR) ? r_q.param[r_q.idx]
                                              : 16'h0000;
      end else if (addr == REG_SECURITY) begin
        r_d.rdata = {6'h00, r_q.lockout, r_q.secured, cfg.sec};
      end else if (addr == REG_PROT) begin
        r_d.rdata = {cfg.dprot, cfg.pprot};
      end else if (addr == REG_OPTION) begin
        r_d.rdata = {8'h00, cfg.opt};
      end else if (addr == REG_QADDR) begin
        r_d.rdata = r_q.qaddr;
      end else if (addr == REG_QUERY) begin
        r_d.rdata = {14'h0000, (qbyte >= PF_BASE),
                     addr_prot(qbyte, cfg.pprot)};
      end else begin
        r_d.rdata = 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      r_q <= REGS_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  assign rdata   = r_q.rdata;
  assign irq     = r_q.irq;
  assign secured = r_q.secured;

endmodule // fbk_flash_ctrl

// ---- hw/fbk_pkg.sv ----
package fbk_pkg;

  // ----------------------------------------------------------------
  // Program flash window and configuration field
  // ----------------------------------------------------------------
  localparam logic [17:0] PF_BASE     = 18'h2_0000; // Lowest flash byte
  localparam logic [17:0] PF_TOP      = 18'h3_FFFF; // Highest flash byte
  localparam logic [17:0] LOWER_BASE  = 18'h3_8000; // Lower region start
  localparam logic [17:0] REGION_UNIT = 18'h0_0800; // Region size step
  localparam logic [17:0] KEY_BASE    = 18'h3_FF00; // Key 0, field start
  localparam int unsigned FIELD_BYTES = 16;         // Field size in bytes
  localparam logic [3:0]  PPROT_OFS   = 4'hC;       // Program protection
  localparam logic [3:0]  DPROT_OFS   = 4'hD;       // Data protection
  localparam logic [3:0]  OPT_OFS     = 4'hE;       // Option byte
  localparam logic [3:0]  SEC_OFS     = 4'hF;       // Security byte
  localparam logic [7:0]  RSVD_BYTE   = 8'hFF;      // Reserved byte value

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  localparam int unsigned PROT_HI_EN  = 0;   // Higher region enable
  localparam int unsigned PROT_LO_EN  = 1;   // Lower region enable
  localparam int unsigned PROT_OT_EN  = 2;   // Remaining area enable
  localparam int unsigned PROT_HI_SZ  = 3;   // Higher size code, 2 bits
  localparam int unsigned PROT_LO_SZ  = 5;   // Lower size code, 2 bits
  localparam logic [1:0]  BACKDOOR_KEY_ENABLE_BITS_ON    = 2'b10; // Backdoor enabled code
  localparam logic [1:0]  SEC_OPEN    = 2'b10; // Unsecured code
  localparam int unsigned ST_COMMAND_COMPLETE_FLAG     = 7;   // Status bit positions
  localparam int unsigned ST_ACCESS_ERROR_FLAG   = 5;
  localparam int unsigned ST_PROTECTION_VIOLATION_FLAG   = 4;
  localparam int unsigned ST_MG1      = 1;
  localparam int unsigned ST_MG0      = 0;
  localparam int unsigned EV_DONE     = 0;   // Interrupt event bits
  localparam int unsigned EV_ACCESS_ERROR_FLAG   = 1;
  localparam int unsigned EV_PROTECTION_VIOLATION_FLAG   = 2;
  localparam int unsigned EV_UNLOCK   = 3;

  // ----------------------------------------------------------------
  // Commands and register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_BACKDOOR = 8'h0C; // Verify backdoor key
  localparam logic [7:0]  CMD_UNSECURE = 8'h0B; // Unsecure flash
  localparam logic [2:0]  IDX_BACKDOOR = 3'h4;  // Last index, Key 3
  localparam logic [7:0]  REG_STATUS   = 8'h00;
  localparam logic [7:0]  REG_INT_STAT = 8'h01;
  localparam logic [7:0]  REG_INT_MASK = 8'h02;
  localparam logic [7:0]  REG_INDEX    = 8'h03;
  localparam logic [7:0]  REG_PARAM    = 8'h04;
  localparam logic [7:0]  REG_SECURITY = 8'h05;
  localparam logic [7:0]  REG_PROT     = 8'h06;
  localparam logic [7:0]  REG_OPTION   = 8'h07;
  localparam logic [7:0]  REG_QADDR    = 8'h08;
  localparam logic [7:0]  REG_QUERY    = 8'h09;

  // Controller sequence states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LAUNCH,
    ST_COMPARE
  } fbk_state_type;

endpackage

// ---- hw/fbk_cfg_if.sv ----
// Configuration field lookup between controller and field store
interface fbk_cfg_if;
  logic [1:0]  key_sel;   // Key number being compared
  logic [15:0] key_word;  // Stored key word for key_sel
  logic [7:0]  pprot;     // Program protection byte
  logic [7:0]  dprot;     // Data protection byte
  logic [7:0]  opt;       // Option byte
  logic [7:0]  sec;       // Security byte

  modport ctrl  (output key_sel, input key_word, pprot, dprot, opt, sec);
  modport store (input key_sel, output key_word, pprot, dprot, opt, sec);
endinterface

// ---- hw/fbk_cfg_field.sv ----
// ------------------------------------------------------------------
// Configuration field store: sixteen bytes of program flash from KEY_BASE
// ------------------------------------------------------------------
module fbk_cfg_field
  import fbk_pkg::*;
#(
  // Field image, byte 0 in the top bits; key values are arbitrary
  parameter logic [127:0] FIELD_INIT = {
    64'h1234_5678_9ABC_DEF0,   // Keys 0 to 3
    32'hFFFF_FFFF,             // Reserved bytes
    8'h00, 8'h00, 8'hFF, 8'h80 // Prot, data prot, option, security
  }
) (
  fbk_cfg_if.store cfg
);

  logic [7:0] field [FIELD_BYTES]; // Field bytes by offset

  // Unpack the image into the byte array
  always_comb begin
    for (int i = 0; i < FIELD_BYTES; i++) begin
      field[i] = FIELD_INIT[8 * (FIELD_BYTES - 1 - i) +: 8];
    end
  end

  // Key n sits at key base plus 2n, high byte first
  assign cfg.key_word = {field[{cfg.key_sel, 2'b00} >> 1],
                         field[({cfg.key_sel, 2'b00} >> 1) + 4'h1]};
  assign cfg.pprot    = field[PPROT_OFS];
  assign cfg.dprot    = field[DPROT_OFS];
  assign cfg.opt      = field[OPT_OFS];
  assign cfg.sec      = field[SEC_OFS];

endmodule // fbk_cfg_field

// ---- bench/fbk_flash_ctrl_properties.sv ----
// ----------------------------------------------------------------------
// Port-level properties of the flash controller
// ----------------------------------------------------------------------
module fbk_flash_ctrl_properties #(
  parameter int unsigned  KEY_WORDS  = 4,  // Keys per verification
  parameter logic [127:0] FIELD_INIT = '0  // Configuration field image
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        special_mode,
  input wire logic        verify_fault,
  input wire logic        verify_uncorrectable,
  input wire logic        irq,
  input wire logic        secured
);
  import fbk_pkg::*;

  logic [3:0]  quiet_q; // Cycles since the last launch, saturating
  logic [15:0] qaddr_q; // Last query address written

  // Follow launches and the query address from the bus
  always_ff @(posedge clk) begin
    if (reset) begin
      quiet_q <= 4'hF;
      qaddr_q <= 16'h0000;
    end else begin
      if (wr && addr == REG_STATUS && wdata[ST_COMMAND_COMPLETE_FLAG]) begin
        quiet_q <= 4'h0;
      end else if (quiet_q != 4'hF) begin
        quiet_q <= quiet_q + 4'h1;
      end
      if (wr && addr == REG_QADDR) begin
        qaddr_q <= wdata;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_unmapped_read;
    rd && addr > REG_QUERY |=> rdata == 16'h0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read gave data");

  property p_rdata_idle;
    !$past(rd) |-> rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its cycle");

  property p_flag_cleared;
    rd && addr == REG_STATUS && quiet_q == 4'h0 |=> !rdata[ST_COMMAND_COMPLETE_FLAG];
  endproperty
  a_flag_cleared: assert property (p_flag_cleared)
    else $error("complete flag high right after launch");

  property p_flag_returns;
    rd && addr == REG_STATUS && quiet_q >= 4'h5 |=> rdata[ST_COMMAND_COMPLETE_FLAG];
  endproperty
  a_flag_returns: assert property (p_flag_returns)
    else $error("complete flag late");

  property p_window;
    rd && addr == REG_QUERY |=> rdata[1] == qaddr_q[15];
  endproperty
  a_window: assert property (p_window)
    else $error("flash window decode wrong");

  property p_release_cause;
    $fell(secured) |->
      quiet_q <= 4'h6 || $past(reset, 2) || $past(reset, 3) ||
      $past(reset, 4);
  endproperty
  a_release_cause: assert property (p_release_cause)
    else $error("security released without a command");

  property p_no_resecure;
    $rose(secured) |-> $past(reset) || $past(reset, 2);
  endproperty
  a_no_resecure: assert property (p_no_resecure)
    else $error("security returned without reset");

  property p_reset_values;
    $fell(reset) |-> secured && !irq && rdata == 16'h0000;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("outputs wrong after reset");

endmodule // fbk_flash_ctrl_properties

bind fbk_flash_ctrl fbk_flash_ctrl_properties #(
  .KEY_WORDS (KEY_WORDS),
  .FIELD_INIT(FIELD_INIT)
) u_props (
  .clk, .reset, .addr, .wdata, .wr, .rd, .rdata, .special_mode,
  .verify_fault, .verify_uncorrectable, .irq, .secured
);

// ---- bench/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fbk_pkg::*;

  // --------------------------------------------------------------------
  // Field images and signals
  // --------------------------------------------------------------------
  // Key values arbitrary; image B protects two regions, no backdoor
  localparam logic [63:0]  KEYS  = 64'h1234_5678_9ABC_DEF0;
  localparam logic [127:0] IMG_A = {KEYS, 32'hFFFF_FFFF, 32'h0000_FF80};
  localparam logic [127:0] IMG_B = {KEYS, 32'hFFFF_FFFF, 32'h0B00_FF00};
  localparam logic [17:0]  QLIST [8] = '{18'h1_FFFC, 18'h2_0000,
    18'h3_8000, 18'h3_87FC, 18'h3_8800, 18'h3_EFFC, 18'h3_F000, 18'h3_FFFC};

  logic        clk, reset, wr, rd, special_mode, irq, irq_b;
  logic        verify_fault, verify_uncorrectable, secured, secured_b;
  logic [7:0]  addr, ua;
  logic [15:0] wdata, rdata, rdata_b, rd_a, rd_b;
  logic [17:0] qa;
  logic [63:0] bad;
  logic [31:0] lfsr_q;
  int          miscompares, num_checks, i;

  fbk_flash_ctrl #(.FIELD_INIT(IMG_A)) uut (
    .clk, .reset, .addr, .wdata, .wr, .rd, .rdata, .special_mode,
    .verify_fault, .verify_uncorrectable, .irq, .secured);
  fbk_flash_ctrl #(.FIELD_INIT(IMG_B)) uut_b (
    .clk, .reset, .addr, .wdata, .wr, .rd, .rdata(rdata_b), .special_mode,
    .verify_fault, .verify_uncorrectable, .irq(irq_b),
    .secured(secured_b));

  // --------------------------------------------------------------------
  // Expectation helpers
  // --------------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Status bits after a finished command
  function automatic logic [15:0] st_exp(input logic a, v, m1, m0);
    return {8'h00, 1'b1, 1'b0, a, v, 2'b00, m1, m0};
  endfunction

  // Whether a flash byte lies in an enabled protection region
  function automatic logic prot_exp(input logic [7:0] p,
                                    input logic [17:0] a);
    logic [17:0] hi_sz, lo_sz;
    hi_sz = REGION_UNIT << p[PROT_HI_SZ +: 2];
    lo_sz = REGION_UNIT << p[PROT_LO_SZ +: 2];
    if (a < PF_BASE) return 1'b0;
    if (a > PF_TOP - hi_sz) return p[PROT_HI_EN];
    if (a >= LOWER_BASE && a < LOWER_BASE + lo_sz) return p[PROT_LO_EN];
    return p[PROT_OT_EN];
  endfunction

  // --------------------------------------------------------------------
  // Bus tasks and comparison
  // --------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    rd_a = rdata;
    rd_b = rdata_b;
  endtask

  task automatic do_reset();
    reset <= 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Load parameters, launch, then poll until both ends finish
  task automatic run_cmd(input logic [7:0] code, input logic [2:0] last,
                         input logic [63:0] keys);
    int n;
    wr_reg(REG_INDEX, 16'h0000);
    wr_reg(REG_PARAM, {code, 8'h00});
    for (n = 1; n <= last; n++) begin
      wr_reg(REG_INDEX, {13'h0000, 3'(n)});
      wr_reg(REG_PARAM, keys[79 - 16 * n -: 16]);
    end
    @(posedge clk);
    addr  <= REG_STATUS;
    wdata <= 16'h0080;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    rd    <= 1'b1;
    @(posedge clk);
    rd    <= 1'b0;
    #1;
    check(rdata & 16'h0080, 16'h0000);
    for (n = 0; n < 20; n++) begin
      rd_reg(REG_STATUS);
      if (rd_a[ST_COMMAND_COMPLETE_FLAG] === 1'b1 && rd_b[ST_COMMAND_COMPLETE_FLAG] === 1'b1) break;
    end
    check(rd_a & 16'h0080, 16'h0080);
  endtask

  task automatic summarize();
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // --------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    summarize();
  end

  initial begin
    {reset, wr, rd, special_mode, verify_fault, verify_uncorrectable} = 6'h20;
    {reset, addr, wdata} = {1'b1, 24'h00_0000};
    {miscompares, num_checks, lfsr_q} = {32'h0, 32'h0, 32'h8827B1D9};
    do_reset();
    // Field bytes as seen through the registers
    rd_reg(REG_SECURITY);
    check(rd_a, 16'h0180);
    check(rd_b, 16'h0100);
    rd_reg(REG_PROT);
    check(rd_b, 16'h000B);
    rd_reg(REG_OPTION);
    check(rd_a, 16'h00FF);
    // Unmapped offsets read zero and ignore writes
    for (i = 0; i < 4; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      ua = (i == 0) ? 8'h0A : {1'b1, lfsr_q[6:0]};
      wr_reg(ua, lfsr_q[31:16]);
      rd_reg(ua);
      check(rd_a, 16'h0000);
    end
    rd_reg(REG_SECURITY);
    check(rd_a, 16'h0180);
    // Flash window and protection regions
    for (i = 0; i < 9; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      qa = (i < 8) ? QLIST[i] : {1'b1, lfsr_q[16:2], 2'b00};
      wr_reg(REG_QADDR, qa[17:2]);
      rd_reg(REG_QUERY);
      check(rd_a & 16'h0003, {14'h0000, qa >= PF_BASE, 1'b0});
      check(rd_b & 16'h0003,
            {14'h0000, qa >= PF_BASE, prot_exp(IMG_B[31:24], qa)});
    end
    wr_reg(REG_INT_MASK, 16'h000F);
    // Unsecure refused: index not zero, then mode not permitted
    special_mode <= 1'b1;
    run_cmd(CMD_UNSECURE, 3'h1, KEYS);
    check(rd_a & 16'h00B3, st_exp(1'b1, 1'b0, 1'b0, 1'b0));
    special_mode <= 1'b0;
    run_cmd(CMD_UNSECURE, 3'h0, KEYS);
    check(rd_a & 16'h00B3, st_exp(1'b1, 1'b0, 1'b0, 1'b0));
    // Verify faults, and protected field on the second end
    special_mode <= 1'b1;
    for (i = 0; i < 2; i++) begin
      {verify_fault, verify_uncorrectable} <= {1'b1, i[0]};
      run_cmd(CMD_UNSECURE, 3'h0, KEYS);
      check(rd_a & 16'h00B3, st_exp(1'b0, 1'b0, 1'b1, i[0]));
      check(rd_b & 16'h0010, 16'h0010);
      check(16'(secured), 16'h0001);
    end
    {verify_fault, verify_uncorrectable} <= 2'b00;
    // Interrupt raised, masked and cleared
    rd_reg(REG_INT_STAT);
    check(rd_a & 16'h000F, 16'h0003);
    check(16'(irq), 16'h0001);
    wr_reg(REG_INT_MASK, 16'h0000);
    rd_reg(REG_INT_STAT);
    check(16'(irq), 16'h0000);
    wr_reg(REG_INT_STAT, 16'h000F);
    wr_reg(REG_INT_MASK, 16'h000F);
    rd_reg(REG_INT_STAT);
    check({rd_a[14:0], irq}, 16'h0000);
    // Matching keys release one end; disabled backdoor refuses
    run_cmd(CMD_BACKDOOR, IDX_BACKDOOR, KEYS);
    check(rd_a & 16'h00B3, st_exp(1'b0, 1'b0, 1'b0, 1'b0));
    check(rd_b & 16'h00B3, st_exp(1'b1, 1'b0, 1'b0, 1'b0));
    check({secured, secured_b, 13'h0000, irq}, 16'h4001);
    // One wrong key in each position locks out later attempts
    for (i = 0; i < 4; i++) begin
      do_reset();
      lfsr_q = lfsr_next(lfsr_q);
      bad = {48'h0, lfsr_q[15:1], 1'b1} << (48 - 16 * i);
      run_cmd(CMD_BACKDOOR, IDX_BACKDOOR, KEYS ^ bad);
      check(16'(secured), 16'h0001);
      run_cmd(CMD_BACKDOOR, IDX_BACKDOOR, KEYS);
      check(rd_a & 16'h00B3, st_exp(1'b1, 1'b0, 1'b0, 1'b0));
      rd_reg(REG_SECURITY);
      check(rd_a & 16'h0300, 16'h0300);
    end
    // Unsecure succeeds only where nothing is protected
    do_reset();
    run_cmd(CMD_UNSECURE, 3'h0, KEYS);
    check(rd_a & 16'h00B3, st_exp(1'b0, 1'b0, 1'b0, 1'b0));
    check(rd_b & 16'h0010, 16'h0010);
    check(16'(secured), 16'h0000);
    // Reset lifts the lockout
    do_reset();
    run_cmd(CMD_BACKDOOR, IDX_BACKDOOR, KEYS);
    check(16'(secured), 16'h0000);
    summarize();
  end
endmodule // testbench
